// [core/wep_top.sv]
// Notes on behaviour
// - With delay enable set, the power event output stays inactive until clocks run and host access is ready.
// - With delay enable clear, an enabled wake event drives the power event output at once.
// - The delay enable only counts while auto wake-up is enabled.
// - The polarity bit makes the power event output active high when one, active low when zero.
// - A four-bit enable field selects wake frame, magic packet, link up and energy events.
// - Only events whose enable bit is one assert the power event output.
// - With auto wake-up in energy-detect mode, energy lasting past the wake time returns to normal power.
// - In the normal-power state with normal or energy-detect mode the MAC may both receive and transmit.
// - With the to-normal bit and auto wake-up, the wake also switches the mode to normal operation.
// - With the to-normal bit clear, the mode stays energy-detect after a wake.
// - Bit 15 is reserved read-only zero, bit 13 is a reserved storage bit with no effect.
// - Wake status in bits 5 to 2 reports energy, link up, magic packet and wake frame events.
// - Wake status is cleared by writing ones or by power-up reset only, and clearing releases the output.
// - A two-bit mode field selects normal, energy-detect, soft power-down or power saving.
// - A timing register holds the go-sleep and wake-up times for energy-detect transitions.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module wep_top
  import wep_pkg::*;
#(
  parameter int UNIT = UNIT_CYC
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // hardware or software reset request, one cycle
  input  wire logic        soft_reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line events, asynchronous levels
  input  wire logic        energy_det,
  input  wire logic        link_up,
  input  wire logic        magic_rx,
  input  wire logic        wake_frame_rx,
  // power outputs
  output logic             power_event_out,
  output logic             low_power,
  output logic             mac_enable,
  output logic       [1:0] power_mode,
  // interrupt
  output logic             irq
);

  logic [15:0]      ctrl;
  logic [15:0]      next_ctrl;
  logic [15:0]      sleep_wake_time_reg;
  logic [15:0]      next_time;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  wep_pstate_type   pstate;
  wep_pstate_type   next_pstate;
  logic [3:0]       line_lvl;
  logic [3:0]       line_prev;
  logic [3:0]       ev;
  logic             pme_out;
  logic             next_pme_out;
  logic [31:0]      next_prdata;
  logic             wr;
  logic             mapped;
  logic [9:0]       idx;
  logic             wake_norm;
  logic             go_sleep;
  logic             ed_mode;
  logic [3:0]       status;
  logic [3:0]       enables;
  logic             pme_active;

  wep_timer_if tif ();

  // line input synchronisers
  wep_sync u_sync_energy
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (energy_det),
    .dout    (line_lvl[EV_ENERGY])
  );
  wep_sync u_sync_link
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (link_up),
    .dout    (line_lvl[EV_LINK])
  );
  wep_sync u_sync_magic
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (magic_rx),
    .dout    (line_lvl[EV_MAGIC])
  );
  wep_sync u_sync_frame
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (wake_frame_rx),
    .dout    (line_lvl[EV_FRAME])
  );

  // rising edges are events; link going down to up
  assign ev = line_lvl & ~line_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_prev <= 4'h0;
    else
      line_prev <= line_lvl;
  end

  // apb decode, zero wait states
  assign idx    = paddr[11:2];
  assign wr     = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00) &&
             ((idx == IDX_CTRL) || (idx == IDX_TIME) || (idx == IDX_IRQ_STAT) ||
              (idx == IDX_IRQ_MASK) || (idx == IDX_STATE));
  end

  // field views
  assign status  = ctrl[STAT_LSB +: 4];
  assign enables = ctrl[EN_LSB +: 4];
  assign ed_mode = (ctrl[MODE_LSB +: 2] == MODE_ENERGY);

  // energy-detect power state timers
  always_comb
  begin
    tif.run   = 1'b0;
    tif.limit = sleep_wake_time_reg[SLEEP_LSB +: 8];
    if (ed_mode)
    begin
      if (pstate == PS_NORMAL)
        tif.run = !line_lvl[EV_ENERGY];
      else
      begin
        tif.run   = line_lvl[EV_ENERGY] && ctrl[BIT_AUTO];
        tif.limit = sleep_wake_time_reg[WAKE_LSB +: 8];
      end
    end
  end

  wep_timer #(.UNIT(UNIT)) u_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif)
  );

  assign go_sleep  = ed_mode && (pstate == PS_NORMAL) && tif.expired;
  assign wake_norm = ed_mode && (pstate == PS_LOW) && tif.expired;

  // power state machine
  always_comb
  begin
    next_pstate = pstate;
    unique case (pstate)
      PS_NORMAL:
      begin
        if (go_sleep)
          next_pstate = PS_LOW;
      end
      PS_LOW:
      begin
        if (!ed_mode)
          next_pstate = PS_NORMAL;
        else if (wake_norm)
          next_pstate = PS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pstate <= PS_NORMAL;
    else
      pstate <= next_pstate;
  end

  // control register with wake status
  always_comb
  begin
    next_ctrl = ctrl;
    if (soft_reset)
      next_ctrl = (CTRL_RESET & CTRL_RW_MASK) | (ctrl & ~CTRL_RW_MASK);
    else if (wr && idx == IDX_CTRL)
    begin
      next_ctrl = (pwdata[15:0] & CTRL_RW_MASK) | (ctrl & ~CTRL_RW_MASK);
      next_ctrl[STAT_LSB +: 4] = status & ~pwdata[STAT_LSB +: 4];
    end
    // with the to-normal bit clear the mode is left alone
    if (wake_norm && ctrl[BIT_TO_NORMAL] && !(wr && idx == IDX_CTRL))
      next_ctrl[MODE_LSB +: 2] = MODE_NORMAL;
    next_ctrl[STAT_LSB +: 4] = next_ctrl[STAT_LSB +: 4] | ev;
    next_ctrl[BIT_RSV15] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // timing register
  always_comb
  begin
    next_time = sleep_wake_time_reg;
    if (soft_reset)
      next_time = TIME_RESET;
    else if (wr && idx == IDX_TIME)
      next_time = pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_wake_time_reg <= TIME_RESET;
    else
      sleep_wake_time_reg <= next_time;
  end

  // interrupt status and mask, set wins over write-one clear
  always_comb
  begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (soft_reset)
    begin
      next_irq_stat = IRQ_RESET;
      next_irq_mask = IRQ_RESET;
    end
    else
    begin
      if (wr && idx == IDX_IRQ_STAT)
        next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
      if (wr && idx == IDX_IRQ_MASK)
        next_irq_mask = pwdata[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | {wake_norm, ev};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      irq      <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq      <= |(next_irq_stat & next_irq_mask);
    end
  end

  // power event output
  always_comb
  begin
    // without delay the assertion follows the status at once
    pme_active = |(status & enables);
    if (ctrl[BIT_AUTO] && ctrl[BIT_DLY] && pstate == PS_LOW)
      pme_active = 1'b0;
    // no pending enabled status leaves the inactive level
    next_pme_out = ctrl[BIT_POL] ? pme_active : !pme_active;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pme_out <= 1'b1;
    else
      pme_out <= next_pme_out;
  end

  assign power_event_out = pme_out;

  // read data captured in the setup phase
  always_comb
  begin
    next_prdata = prdata;
    if (psel && !penable)
    begin
      next_prdata = 32'h0000_0000;
      if (paddr[1:0] == 2'b00)
      begin
        unique case (idx)
          IDX_CTRL:     next_prdata[15:0]      = ctrl;
          IDX_TIME:     next_prdata[15:0]      = sleep_wake_time_reg;
          IDX_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_stat;
          IDX_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
          IDX_STATE:    next_prdata[0]         = pstate;
          default:      next_prdata            = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= next_prdata;
  end

  // power outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_power  <= 1'b0;
      mac_enable <= 1'b1;
      power_mode <= MODE_NORMAL;
    end
    else
    begin
      low_power  <= (next_pstate == PS_LOW);
      mac_enable <= (next_pstate == PS_NORMAL) &&
                    ((next_ctrl[MODE_LSB +: 2] == MODE_NORMAL) ||
                     (next_ctrl[MODE_LSB +: 2] == MODE_ENERGY));
      power_mode <= next_ctrl[MODE_LSB +: 2];
    end
  end

endmodule // wep_top

// [core/wep_pkg.sv]
package wep_pkg;

  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_CTRL      = 10'h0D4;
  localparam logic [9:0]  IDX_TIME      = 10'h0D6;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h0E0;
  localparam logic [9:0]  IDX_IRQ_MASK  = 10'h0E1;
  localparam logic [9:0]  IDX_STATE     = 10'h0E2;

  // power_event_control fields
  localparam int          BIT_RSV15     = 15;
  localparam int          BIT_DLY       = 14;
  localparam int          BIT_RSV13     = 13;
  localparam int          BIT_POL       = 12;
  localparam int          EN_LSB        = 8;
  localparam int          BIT_AUTO      = 7;
  localparam int          BIT_TO_NORMAL = 6;
  localparam int          STAT_LSB      = 2;
  localparam int          MODE_LSB      = 0;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_RW_MASK  = 16'h7FC3;

  // sleep_wake_time_reg fields: wake time low byte, go-sleep time high byte
  localparam int          WAKE_LSB      = 0;
  localparam int          SLEEP_LSB     = 8;
  localparam logic [15:0] TIME_RESET    = 16'h0A0A;

  // event vector positions, shared by wake status and interrupt status
  localparam int          EV_ENERGY     = 0;
  localparam int          EV_LINK       = 1;
  localparam int          EV_MAGIC      = 2;
  localparam int          EV_FRAME      = 3;
  localparam int          IRQ_WAKE_NORM = 4;
  localparam int          IRQ_W         = 5;
  localparam logic [4:0]  IRQ_RESET     = 5'h00;

  // timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          TIME_UNIT_NS  = 1000;
  localparam int          UNIT_CYC      = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    MODE_NORMAL   = 2'b00,
    MODE_ENERGY   = 2'b01,
    MODE_SOFT_PD  = 2'b10,
    MODE_SAVING   = 2'b11
  } wep_mode_type;

  typedef enum logic
  {
    PS_NORMAL = 1'b0,
    PS_LOW    = 1'b1
  } wep_pstate_type;

endpackage

// [core/wep_timer_if.sv]
`timescale 1ns/1ps
interface wep_timer_if;
  logic       run;
  logic [7:0] limit;
  logic       expired;
  modport ctrl  (output run, output limit, input expired);
  modport timer (input run, input limit, output expired);
endinterface // wep_timer_if

// [core/wep_sync.sv]
`timescale 1ns/1ps
module wep_sync
  import wep_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // async level in, filtered level out
  input  wire logic din,
  output logic      dout
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_dout;

  always_comb
  begin
    next_stage = {stage[1:0], din};
    // change counts once the second and third stage agree
    next_dout  = (stage[1] == stage[2]) ? stage[2] : dout;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage <= 3'h0;
      dout  <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      dout  <= next_dout;
    end
  end

endmodule // wep_sync

// [core/wep_timer.sv]
`timescale 1ns/1ps
module wep_timer
  import wep_pkg::*;
#(
  parameter int UNIT = UNIT_CYC
)
(
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // control
  wep_timer_if.timer  tif
);

  logic [15:0] pre;
  logic [15:0] next_pre;
  logic [8:0]  units;
  logic [8:0]  next_units;

  // counts whole time units while run stays high, saturating
  always_comb
  begin
    next_pre   = pre;
    next_units = units;
    if (!tif.run)
    begin
      next_pre   = 16'h0000;
      next_units = 9'h000;
    end
    else if (pre == 16'(UNIT - 1))
    begin
      next_pre = 16'h0000;
      if (units != 9'h1FF)
        next_units = units + 9'h001;
    end
    else
      next_pre = pre + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre   <= 16'h0000;
      units <= 9'h000;
    end
    else
    begin
      pre   <= next_pre;
      units <= next_units;
    end
  end

  // strictly longer than the programmed time
  assign tif.expired = tif.run && (units > {1'b0, tif.limit});

endmodule // wep_timer

// [bench/wep_line_model.sv]
`timescale 1ns/1ps
module wep_line_model
(
  // clock
  input  wire logic pclk,
  // line events: energy, link up, magic packet, wake frame
  output logic [3:0] ev
);
  initial ev = 4'h0;

  // one event: a level held for len clocks, never shorter than three
  task automatic pulse(input int i, input int len);
    @(posedge pclk);
    ev[i] <= 1'b1;
    repeat (len) @(posedge pclk);
    ev[i] <= 1'b0;
  endtask
endmodule // wep_line_model

// [bench/wep_props.sv]
`timescale 1ns/1ps
module wep_props
  import wep_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        soft_reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line events
  input wire logic        energy_det,
  input wire logic        link_up,
  input wire logic        magic_rx,
  input wire logic        wake_frame_rx,
  // power outputs and interrupt
  input wire logic        power_event_out,
  input wire logic        low_power,
  input wire logic        mac_enable,
  input wire logic [1:0]  power_mode,
  input wire logic        irq
);
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  logic [15:0] ctrl_sh, next_ctrl_sh;
  logic [4:0]  mask_sh, next_mask_sh;
  logic        wr_en;

  // shadow of the host-written control and mask values
  assign wr_en = psel && penable && pwrite && pready;
  always_comb
  begin
    next_ctrl_sh = ctrl_sh;
    next_mask_sh = mask_sh;
    if (soft_reset)
    begin
      next_ctrl_sh = 16'h0000;
      next_mask_sh = 5'h00;
    end
    else if (wr_en && paddr == A_CTRL)
      next_ctrl_sh = pwdata[15:0] & CTRL_RW_MASK;
    else if (wr_en && paddr == A_MASK)
      next_mask_sh = pwdata[4:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_sh <= 16'h0000;
      mask_sh <= 5'h00;
    end
    else
    begin
      ctrl_sh <= next_ctrl_sh;
      mask_sh <= next_mask_sh;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rsv_zero: assert property
    (psel && penable && !pwrite && paddr == A_CTRL |-> prdata[31:15] == 17'h0)
    else $error("reserved control bits read nonzero");
  a_pin_idle: assert property
    (ctrl_sh[11:8] == 4'h0 && $stable(ctrl_sh) |-> power_event_out == !ctrl_sh[12])
    else $error("power event pin not idle");
  a_event_pin: assert property
    ($rose(magic_rx) && ctrl_sh[10] && !ctrl_sh[7] |-> ##[4:6] power_event_out == ctrl_sh[12])
    else $error("enabled event did not drive the pin");
  a_clear_release: assert property
    (wr_en && paddr == A_CTRL && pwdata[5:2] == 4'hF |-> ##2 power_event_out == !ctrl_sh[12])
    else $error("status clear did not release the pin");
  a_irq_masked: assert property
    (mask_sh == 5'h00 && $past(mask_sh) == 5'h00 |-> !irq)
    else $error("interrupt with all sources masked");
  a_no_wake_off: assert property
    (low_power && !ctrl_sh[7] && ctrl_sh[1:0] == 2'b01 && !soft_reset && !wr_en |=> low_power)
    else $error("woke with auto wake-up off");
  a_wake_normal_mode: assert property
    ($fell(low_power) && ctrl_sh[7:6] == 2'b11 && ctrl_sh[1:0] == 2'b01
      |-> ##[0:2] power_mode == 2'b00)
    else $error("wake did not switch to normal mode");
  a_mode_follow: assert property
    (wr_en && paddr == A_CTRL |-> ##2 power_mode == ctrl_sh[1:0])
    else $error("power mode does not follow control");
  a_delay_hold: assert property
    (low_power && $past(low_power) && ctrl_sh[14] && ctrl_sh[7] && $stable(ctrl_sh)
      |-> power_event_out == !ctrl_sh[12])
    else $error("pin asserted before wake with delay");
  a_low_mac_off: assert property
    (low_power |-> !mac_enable)
    else $error("mac enabled in low power");
  a_apb_ready: assert property
    (psel && penable |-> pready)
    else $error("apb access phase without ready");
endmodule // wep_props

bind wep_top wep_props wep_props_i (.*);

// [bench/wep_top_tb_top.sv]
`timescale 1ns/1ps
module wep_top_tb_top;
  import wep_pkg::*;
  localparam logic [11:0] A_CTRL  = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_TIME  = {IDX_TIME, 2'b00};
  localparam logic [11:0] A_ISTAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK  = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_STATE = {IDX_STATE, 2'b00};
  logic        pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, s;
  logic [3:0]  ev;
  logic        power_event_out, low_power, mac_enable, irq;
  logic [1:0]  power_mode;
  logic [32:0] expq[$];
  logic [32:0] x;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  int          seed = 32'h0378;
  int          j;

  wep_line_model wep_line_model_i (.pclk(pclk), .ev(ev));
  wep_top #(.UNIT(1)) wep_top_i
  (
    .pclk(pclk), .presetn(presetn), .soft_reset(soft_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .energy_det(ev[EV_ENERGY]), .link_up(ev[EV_LINK]), .magic_rx(ev[EV_MAGIC]),
    .wake_frame_rx(ev[EV_FRAME]), .power_event_out(power_event_out),
    .low_power(low_power), .mac_enable(mac_enable), .power_mode(power_mode), .irq(irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    expq.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  function automatic int len();
    return 3 + int'($unsigned($random(seed)) % 5);
  endfunction

  // read monitor: oldest expectation against each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      x = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, x[32]});
      chk(prdata, x[31:0]);
    end
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      give_verdict();
    end
  end

  initial
  begin
    {soft_reset, psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(power_event_out), 32'h1);
    rd(A_CTRL, 32'h0, 1'b0);
    rd(A_TIME, 32'(TIME_RESET), 1'b0);
    rd(A_ISTAT, 32'h0, 1'b0);
    wr(A_CTRL, 32'hFFFF);
    rd(A_CTRL, 32'(CTRL_RW_MASK), 1'b0);
    rd(12'h354, 32'h0, 1'b1);
    for (int m = 3; m >= 0; m--)
    begin
      wr(A_CTRL, 32'(m));
      repeat (2) @(negedge pclk);
      chk(32'(power_mode), 32'(m));
    end
    // each event enabled alone, a disabled one first, both polarities
    wr(A_MASK, 32'h1F);
    for (int i = 0; i < 4; i++)
    begin
      j = (i + 1) % 4;
      v = 32'((i & 1) << BIT_POL | 1 << (EN_LSB + i) | ($random(seed) & 1) << BIT_RSV13);
      wr(A_CTRL, v);
      wep_line_model_i.pulse(j, len());
      repeat (8) @(negedge pclk);
      chk(32'(power_event_out), 32'(!v[BIT_POL]));
      wep_line_model_i.pulse(i, len());
      repeat (8) @(negedge pclk);
      chk(32'(power_event_out), 32'(v[BIT_POL]));
      chk(32'(irq), 32'h1);
      s = 32'(1 << i | 1 << j);
      rd(A_CTRL, v | s << STAT_LSB, 1'b0);
      rd(A_ISTAT, s, 1'b0);
      wr(A_CTRL, v | 32'h3C);
      wr(A_ISTAT, 32'h1F);
      repeat (2) @(negedge pclk);
      chk(32'(power_event_out), 32'(!v[BIT_POL]));
      chk(32'(irq), 32'h0);
    end
    // energy-detect: sleep, wake with and without auto wake-up
    wr(A_MASK, 32'h0);
    wr(A_TIME, 32'h0202);
    wr(A_CTRL, 32'h5101);
    repeat (20) @(negedge pclk);
    chk(32'(low_power), 32'h1);
    chk(32'(mac_enable), 32'h0);
    rd(A_STATE, 32'h1, 1'b0);
    wep_line_model_i.pulse(0, 20);
    @(negedge pclk);
    chk(32'(low_power), 32'h1);
    chk(32'(power_event_out), 32'h1);
    wr(A_CTRL, 32'h0081);
    wep_line_model_i.pulse(0, 20);
    @(negedge pclk);
    chk(32'(low_power), 32'h0);
    chk(32'(power_mode), 32'h1);
    chk(32'(mac_enable), 32'h1);
    rd(A_ISTAT, 32'h11, 1'b0);
    repeat (20) @(negedge pclk);
    chk(32'(low_power), 32'h1);
    wr(A_TIME, 32'h0210);
    wr(A_CTRL, 32'h51C1);
    fork
      wep_line_model_i.pulse(0, 40);
      begin
        repeat (10) @(negedge pclk);
        chk(32'(power_event_out), 32'h0);
      end
    join
    @(negedge pclk);
    chk(32'(low_power), 32'h0);
    chk(32'(power_mode), 32'h0);
    chk(32'(power_event_out), 32'h1);
    // soft reset keeps wake status, restores the rest
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(A_CTRL, 32'h4, 1'b0);
    rd(A_TIME, 32'(TIME_RESET), 1'b0);
    @(negedge pclk);
    give_verdict();
  end
endmodule // wep_top_tb_top
